// file: include/hls_defines.svh
`ifndef HLS_DEFINES_SVH
`define HLS_DEFINES_SVH
// release hold of a sustained tri-state line before letting go, in clocks
`define HLS_REL_HOLD_CLKS 2'h1
// quiet gap after release before a new owner may drive, in clocks
`define HLS_OWN_GAP_CLKS 2'h1
// message slot count in the unacknowledged table
`define HLS_MSG_SLOTS 4
// reset value of the link select: smbus
`define HLS_SEL_RST 1'h0
`endif

// file: include/hls_pkg.sv
package hls_pkg;
  typedef enum logic [1:0] {
    HLS_LINK_SMB = 2'b00,
    HLS_LINK_PCIE = 2'b01,
    HLS_LINK_OFF = 2'b10
  } hls_link_t;
  typedef enum logic [1:0] {
    HLS_OWN_IDLE = 2'b00,
    HLS_OWN_DRIVE = 2'b01,
    HLS_OWN_HIGH = 2'b10,
    HLS_OWN_GAP = 2'b11
  } hls_own_t;
endpackage

// file: rtl/hls_switch.sv
`timescale 1ns/1ps
`include "hls_defines.svh"
// Functional notes
// [R01] While link_reset_n is high all traffic goes over the pcie link.
// [R02] While link_reset_n is low traffic goes over the smbus link.
// [R03] A packet still in progress when link_reset_n falls is dropped.
// [R04] On moving to smbus every unacknowledged in-band message is resent over smbus.
// [R05] The management engine and platform hub decide when to move to smbus.
// [R06] A sustained tri-state line has one driver, is driven high a clock before release, and a new owner waits a clock.
// [R07] With device_disable_n low the device is disabled.
// [R08] On moving back to pcie every unacknowledged in-band message is resent over pcie.
// [R09] link_reset_n is synchronised before it selects the link, so the switch is one clean edge.
module hls_switch #(
  parameter int SLOTS = `HLS_MSG_SLOTS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic link_reset_pin_n,
  input wire logic device_disable_n,
  // packet in flight from the phy core
  input wire logic pkt_active,
  // in-band message sent: slot index and strobe
  input wire logic msg_sent,
  input wire logic [$clog2(SLOTS)-1:0] msg_sent_idx,
  input wire logic msg_ack,
  input wire logic [$clog2(SLOTS)-1:0] msg_ack_idx,
  // resend port: accepted by the link engine when resend_ready
  input wire logic resend_ready,
  // sustained tri-state line request from the core (drive low when asserted)
  input wire logic sts_req,
  input wire logic sts_in,
  output logic sts_out,
  output logic sts_oe,
  output logic sel_pcie,
  output logic sel_smb,
  output logic pkt_drop,
  output logic resend_valid,
  output logic [$clog2(SLOTS)-1:0] resend_idx,
  output logic dev_enabled
);
  localparam int IW = $clog2(SLOTS);
  logic [2:0] rst_sync;
  logic [2:0] dis_sync;
  logic link_up;
  logic enabled;
  logic [SLOTS-1:0] pend;
  logic [SLOTS-1:0] resend_set;
  hls_pkg::hls_own_t own;
  hls_pkg::hls_own_t next_own;
  // lowest pending slot; used for the resend pick
  function automatic logic [IW-1:0] first_set(input logic [SLOTS-1:0] v);
    logic [IW-1:0] r;
    r = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IW'(i);
      end
    end
    return r;
  endfunction

  // [R09] three-stage sync, change taken when stages 2 and 3 agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_sync <= 3'h0;
      dis_sync <= 3'h0;
    end else begin
      rst_sync <= {rst_sync[1:0], link_reset_pin_n};
      dis_sync <= {dis_sync[1:0], device_disable_n};
    end
  end

  wire rst_agree = rst_sync[2] == rst_sync[1];
  wire dis_agree = dis_sync[2] == dis_sync[1];
  wire next_link_up = rst_agree ? rst_sync[2] : link_up;
  wire next_enabled = dis_agree ? dis_sync[2] : enabled;
  wire link_change = next_link_up != link_up;
  wire link_fall = link_up && !next_link_up;
  // resend whenever the link moves while enabled; a disable discards the table
  wire do_resend = link_change && next_enabled;
  wire fire = resend_valid && resend_ready;

  // filtered levels: link choice and device enable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link_up <= `HLS_SEL_RST;
      enabled <= 1'h0;
    end else begin
      link_up <= next_link_up;
      enabled <= next_enabled;
    end
  end

  // [R01] [R02] [R07] select follows the filtered reset; disable parks both
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_pcie <= 1'h0;
      sel_smb <= 1'h0;
      dev_enabled <= 1'h0;
    end else begin
      sel_pcie <= next_enabled && next_link_up;
      sel_smb <= next_enabled && !next_link_up;
      dev_enabled <= next_enabled;
    end
  end

  // [R03] drop pulse when the link falls mid-packet
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pkt_drop <= 1'h0;
    end else begin
      pkt_drop <= link_fall && pkt_active;
    end
  end

  // unacknowledged table; a send in the same cycle as an ack wins
  always_comb begin
    resend_set = pend;
    if (msg_ack) begin
      resend_set[msg_ack_idx] = 1'b0;
    end
    if (msg_sent) begin
      resend_set[msg_sent_idx] = 1'b1;
    end
    if (!enabled) begin
      resend_set = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend <= '0;
    end else begin
      pend <= resend_set;
    end
  end

  // [R04] [R08] walk pending slots out on the new link after each switch
  logic [SLOTS-1:0] queue;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      queue <= '0;
      resend_valid <= 1'h0;
      resend_idx <= '0;
    end else begin
      if (do_resend) begin
        queue <= resend_set;
        resend_valid <= 1'h0;
      end else if (!enabled) begin
        queue <= '0;
        resend_valid <= 1'h0;
      end else if (!resend_valid || fire) begin
        resend_valid <= |queue;
        resend_idx <= first_set(queue);
        queue <= queue & ~(SLOTS'(|queue) << first_set(queue));
      end
    end
  end

  // [R06] ownership sequence: drive low, drive high one clock, release, gap
  always_comb begin
    next_own = own;
    case (own)
      hls_pkg::HLS_OWN_IDLE: begin
        if (sts_req && enabled && sts_in) begin
          next_own = hls_pkg::HLS_OWN_DRIVE;
        end
      end
      hls_pkg::HLS_OWN_DRIVE: begin
        if (!sts_req || !enabled) begin
          next_own = hls_pkg::HLS_OWN_HIGH;
        end
      end
      hls_pkg::HLS_OWN_HIGH: next_own = hls_pkg::HLS_OWN_GAP;
      hls_pkg::HLS_OWN_GAP: next_own = hls_pkg::HLS_OWN_IDLE;
      default: next_own = hls_pkg::HLS_OWN_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      own <= hls_pkg::HLS_OWN_IDLE;
      sts_out <= 1'h1;
      sts_oe <= 1'h0;
    end else begin
      own <= next_own;
      sts_out <= next_own != hls_pkg::HLS_OWN_DRIVE;
      sts_oe <= next_own == hls_pkg::HLS_OWN_DRIVE || next_own == hls_pkg::HLS_OWN_HIGH;
    end
  end

  // checks
  // link was up with a packet in flight, then fell on the next clock
  sequence s_fall;
    link_up && pkt_active ##1 !link_up;
  endsequence
  property p_pcie_sel;
    @(posedge clk) disable iff (sys_rst) (link_up && enabled) |-> sel_pcie;
  endproperty
  a_pcie_sel: assert property (p_pcie_sel) else $error("pcie not selected"); // [R01]
  property p_smb_sel;
    @(posedge clk) disable iff (sys_rst) (!link_up && enabled) |-> sel_smb && !sel_pcie;
  endproperty
  a_smb_sel: assert property (p_smb_sel) else $error("smbus not selected"); // [R02]
  property p_drop;
    @(posedge clk) disable iff (sys_rst) s_fall |-> pkt_drop;
  endproperty
  a_drop: assert property (p_drop) else $error("packet not dropped"); // [R03]
  property p_resend_smb;
    @(posedge clk) disable iff (sys_rst) (link_up && !next_link_up && enabled && |resend_set && resend_ready
      && next_enabled) |-> ##[1:3] resend_valid;
  endproperty
  a_resend_smb: assert property (p_resend_smb) else $error("no resend on smbus"); // [R04]
  property p_resend_pcie;
    @(posedge clk) disable iff (sys_rst) (!link_up && next_link_up && |resend_set && next_enabled)
      |-> ##[1:3] resend_valid;
  endproperty
  a_resend_pcie: assert property (p_resend_pcie) else $error("no resend on pcie"); // [R08]
  property p_high_before_release;
    @(posedge clk) disable iff (sys_rst) ($fell(sts_oe)) |-> $past(sts_out);
  endproperty
  a_high_before_release: assert property (p_high_before_release) else $error("released while low"); // [R06]
  property p_disabled;
    @(posedge clk) disable iff (sys_rst) !dev_enabled |-> !sel_pcie && !sel_smb;
  endproperty
  a_disabled: assert property (p_disabled) else $error("link active while disabled"); // [R07]
  property p_sync;
    @(posedge clk) disable iff (sys_rst) $changed(link_up) |-> $past(rst_sync[2]) == $past(rst_sync[1]);
  endproperty
  a_sync: assert property (p_sync) else $error("unsynchronised switch"); // [R09]
endmodule

// file: verification/hls_lan_model.sv
`timescale 1ns/1ps
// lan controller side: takes resends and shares the sustained line
module hls_lan_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic sts_out,
  input wire logic sts_oe,
  output logic resend_ready,
  output logic sts_in
);
  assign sts_in = sts_oe ? sts_out : 1'h1;
  // slow mode takes every other cycle so resends must wait
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      resend_ready <= 1'h0;
    end else begin
      resend_ready <= slow ? ~resend_ready : 1'h1;
    end
  end
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic pin = 1'h0;
  logic dis_n = 1'h0;
  logic pkt = 1'h0;
  logic sent = 1'h0;
  logic ack = 1'h0;
  logic [1:0] idx = 2'h0;
  logic sts_req = 1'h0;
  logic slow = 1'h0;
  logic sts_in, sts_out, sts_oe, sel_pcie, sel_smb, pkt_drop, resend_valid, resend_ready, dev_enabled;
  logic [1:0] resend_idx;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  hls_switch #(.SLOTS(4)) uut (.clk(clk), .sys_rst(sys_rst), .link_reset_pin_n(pin),
    .device_disable_n(dis_n), .pkt_active(pkt), .msg_sent(sent), .msg_sent_idx(idx), .msg_ack(ack),
    .msg_ack_idx(idx), .resend_ready(resend_ready), .sts_req(sts_req), .sts_in(sts_in), .sts_out(sts_out),
    .sts_oe(sts_oe), .sel_pcie(sel_pcie), .sel_smb(sel_smb), .pkt_drop(pkt_drop),
    .resend_valid(resend_valid), .resend_idx(resend_idx), .dev_enabled(dev_enabled));
  hls_lan_model peer (.clk(clk), .sys_rst(sys_rst), .slow(slow), .sts_out(sts_out), .sts_oe(sts_oe),
    .resend_ready(resend_ready), .sts_in(sts_in));
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // wait n edges, then let their updates settle
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one-cycle send or acknowledge of a slot
  task automatic note(input logic s, input logic [1:0] i);
    @(posedge clk);
    sent <= s;
    ack <= ~s;
    idx <= i;
    @(posedge clk);
    sent <= 1'h0;
    ack <= 1'h0;
  endtask
  // the pin moves, the select must not move early, then drop flags the switch cycle
  task automatic switch_to(input logic p, input logic drop);
    int n;
    @(posedge clk);
    pin <= p;
    tick(2);
    chk(sel_pcie, !p);
    n = 0;
    while (sel_pcie !== p && n < 10) begin
      tick(1);
      n++;
    end
    chk({sel_pcie, sel_smb, pkt_drop}, {p, ~p, drop});
  endtask
  // two resends in slot order, then nothing more
  task automatic drain(input logic [1:0] a, input logic [1:0] b);
    int n;
    logic [1:0] want [2];
    want = '{a, b};
    foreach (want[k]) begin
      n = 0;
      while (!(resend_valid === 1'h1 && resend_ready === 1'h1) && n < 10) begin
        tick(1);
        n++;
      end
      chk(resend_idx, want[k]);
      tick(1);
    end
    chk(resend_valid, 1'h0);
  endtask
  // owner drives low, then high one clock, then lets go
  task automatic sts_test;
    @(posedge clk);
    sts_req <= 1'h1;
    tick(1);
    chk({sts_oe, sts_out, sts_in}, 3'b100);
    @(posedge clk);
    sts_req <= 1'h0;
    tick(1);
    chk({sts_oe, sts_out, sts_in}, 3'b111);
    tick(1);
    chk({sts_oe, sts_in}, 2'b01);
  endtask
  // disabled device parks both links, then ignores the line request
  // the request waits for the disable to pass the sync, or it would be taken first
  task automatic dis_test;
    @(posedge clk);
    dis_n <= 1'h0;
    tick(6);
    chk({dev_enabled, sel_pcie, sel_smb}, 3'b000);
    @(posedge clk);
    sts_req <= 1'h1;
    tick(3);
    chk({sts_oe, sts_out}, 2'b01);
  endtask
  task automatic finish_test;
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      finish_test;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'h0;
    tick(1);
    chk({sts_oe, sts_out, dev_enabled, resend_valid}, 4'b0100);
    @(posedge clk);
    dis_n <= 1'h1;
    switch_to(1'h1, 1'h0);
    chk(dev_enabled, 1'h1);
    note(1'h1, 2'h1);
    note(1'h1, 2'h2);
    note(1'h1, 2'h3);
    note(1'h0, 2'h3);
    @(posedge clk);
    pkt <= 1'h1;
    slow <= 1'h1;
    // management engine asks for the low power link
    switch_to(1'h0, 1'h1);
    drain(2'h1, 2'h2);
    note(1'h0, 2'h1);
    note(1'h0, 2'h2);
    note(1'h1, 2'h0);
    note(1'h1, 2'h3);
    @(posedge clk);
    pkt <= 1'h0;
    switch_to(1'h1, 1'h0);
    drain(2'h0, 2'h3);
    sts_test;
    dis_test;
    finish_test;
  end
endmodule
